// ---- design/fcdl_pkg.sv ----
// Constants, field layouts and carrier types for fuse decoding and lock.
package fcdl_pkg;

  // Fuse byte offsets within the fuse space
  localparam logic [7:0] FUSE_OFS_SYSTEM_CONFIG_ZERO_FUSE = 8'h05;
  localparam logic [7:0] FUSE_OFS_SYSTEM_CONFIG_ONE_FUSE = 8'h06;
  localparam logic [7:0] FUSE_OFS_CODE_REGION_SIZE = 8'h07;
  localparam logic [7:0] FUSE_OFS_BOOT_REGION_SIZE = 8'h08;
  // Lock key word offset; bytes sit at offsets 0 to 3, low byte first
  localparam logic [7:0] LOCK_OFS_KEY = 8'h00;
  localparam logic [7:0] LOCK_KEY_BYTES = 8'h04;

  // Field positions
  localparam int DEBUG_PIN_BIT = 4;
  localparam int RESET_PIN_BIT = 3;
  localparam int EEPROM_KEEP_BIT = 0;
  localparam int SUPPLY_MSB = 4;
  localparam int SUPPLY_LSB = 3;
  localparam int STARTUP_MSB = 2;
  localparam int STARTUP_LSB = 0;

  // Encodings
  localparam logic [31:0] UNLOCK_KEY = 32'h5CC5_C55C;
  localparam logic [1:0] SUPPLY_DUAL = 2'h1;
  localparam logic [1:0] SUPPLY_SINGLE = 2'h2;
  localparam logic [2:0] STARTUP_NONE = 3'h0;
  localparam logic [7:0] BOOT_SIZE_ALL = 8'h00;
  localparam logic [7:0] INVALID_DATA = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Region sizes count 512-byte blocks
  localparam int REGION_UNIT_BYTES = 512;
  localparam int REGION_SHIFT = $clog2(REGION_UNIT_BYTES);
  localparam int REGION_ADDR_W = 8 + REGION_SHIFT;
  localparam int FLASH_BYTES_DEFAULT = 32768;

  // Start-up delay timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int DELAY_UNIT_MS = 1;
  localparam int NS_PER_MS = 1000000;
  localparam int CYCLES_PER_MS =
    (DELAY_UNIT_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DELAY_MS_W = 7;

  typedef enum logic [2:0] {
    sec_flash, sec_sram, sec_eeprom, sec_signature_row,
    sec_user_row_a, sec_fuse, sec_lock, sec_regs
  } fcdl_section_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic fuse_cmd;
    fcdl_section_type section;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fcdl_req_type;

  typedef struct packed {
    logic done;
    logic refused;
    logic [7:0] rdata;
  } fcdl_resp_type;

  typedef struct packed {
    logic [7:0] system_config_zero_fuse;
    logic [7:0] system_config_one_fuse;
    logic [7:0] code_size;
    logic [7:0] boot_size;
    logic [31:0] key;
  } fcdl_fuse_type;

  typedef struct packed {
    logic debug_pin_function_select;
    logic debug_pin_pullup;
    logic reset_pin_function_select;
    logic eeprom_keep_on_erase;
    logic supply_dual;
    logic supply_single;
    logic supply_reserved;
    logic [REGION_ADDR_W:0] boot_region_end;
    logic [REGION_ADDR_W:0] code_region_end;
  } fcdl_cfg_type;

endpackage : fcdl_pkg

// ---- design/fcdl_startup_timer.sv ----
// Start-up delay counter: waits 0 or 2^(code-1) milliseconds.
`timescale 1ns/1ps
`default_nettype none
module fcdl_startup_timer
  import fcdl_pkg::*;
#(
  parameter int CYCLES_MS = CYCLES_PER_MS
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // Control
  input wire logic start,
  input wire logic [2:0] delay_code,
  // Status
  output logic done
);

  localparam int CNT_W = $clog2(CYCLES_MS + 1);
  localparam logic [CNT_W-1:0] LAST_CYCLE = CNT_W'(CYCLES_MS - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [DELAY_MS_W-1:0] MS_ONE = DELAY_MS_W'(1);

  typedef enum logic [1:0] {st_idle, st_count, st_done} fcdl_tmr_type;

  fcdl_tmr_type state, next_state;
  logic [CNT_W-1:0] cyc, next_cyc;
  logic [DELAY_MS_W-1:0] ms_left, next_ms_left;

  always_comb
  begin
    next_state = state;
    next_cyc = cyc;
    next_ms_left = ms_left;
    unique case (state)
      st_idle:
        if (start)
        begin
          if (delay_code == STARTUP_NONE)
            next_state = st_done;
          else
          begin
            next_state = st_count;
            next_cyc = CNT_ZERO;
            next_ms_left = MS_ONE << (delay_code - 3'h1);
          end
        end
      st_count:
        if (cyc == LAST_CYCLE)
        begin
          next_cyc = CNT_ZERO;
          next_ms_left = ms_left - MS_ONE;
          if (ms_left == MS_ONE)
            next_state = st_done;
        end
        else
          next_cyc = cyc + CNT_W'(1);
      st_done:
        next_state = st_done;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= st_idle;
      cyc <= CNT_ZERO;
      ms_left <= '0;
    end
    else if (ce)
    begin
      state <= next_state;
      cyc <= next_cyc;
      ms_left <= next_ms_left;
    end
  end

  assign done = (state == st_done);

endmodule : fcdl_startup_timer
`default_nettype wire

// ---- design/fcdl_fuse_lock.sv ----
// Fuse decoding, start-up delay and debugger access protection.
`timescale 1ns/1ps
`default_nettype none
module fcdl_fuse_lock
  import fcdl_pkg::*;
#(
  parameter int FLASH_BYTES = FLASH_BYTES_DEFAULT,
  parameter int CYCLES_MS = CYCLES_PER_MS
)
(
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // Raw fuse and key contents from the array
  input wire fcdl_fuse_type fuse_in,
  // Debugger side
  input wire fcdl_req_type dbg_req,
  input wire logic dbg_erase,
  input wire logic dbg_mem_rvalid,
  input wire logic [7:0] dbg_mem_rdata,
  output fcdl_req_type dbg_mem,
  output fcdl_resp_type dbg_resp,
  // Processor side
  input wire fcdl_req_type cpu_req,
  output fcdl_req_type cpu_mem,
  output fcdl_resp_type cpu_resp,
  // Erase strobes
  output logic erase_flash,
  output logic erase_sram,
  output logic erase_eeprom,
  // Decoded settings and status
  output fcdl_cfg_type cfg,
  output logic locked,
  output logic config_valid,
  output logic code_exec_en
);

  localparam logic [REGION_ADDR_W:0] FLASH_END =
    (REGION_ADDR_W+1)'(FLASH_BYTES);

  typedef enum logic [1:0] {st_load, st_delay, st_run} fcdl_state_type;

  fcdl_state_type state, next_state;
  fcdl_fuse_type held, next_held;
  fcdl_cfg_type next_cfg;
  fcdl_req_type next_dbg_mem, next_cpu_mem;
  fcdl_resp_type next_dbg_resp, next_cpu_resp;
  logic pend, next_pend;
  logic next_erase_flash, next_erase_sram, next_erase_eeprom;
  logic timer_start, timer_done;
  logic key_ok;

  // Rights for one access; the same table serves both parties
  function automatic logic access_ok(input fcdl_section_type sec,
                                     input logic wr,
                                     input logic fuse_cmd,
                                     input logic is_dbg,
                                     input logic lk);
    logic ok;
    ok = 1'b1;
    if (!is_dbg)
      ok = !(wr && (sec == sec_signature_row || sec == sec_fuse ||
                    sec == sec_lock));
    else if (lk)
      ok = wr && fuse_cmd && (sec == sec_user_row_a);
    else
      ok = !(wr && sec == sec_signature_row);
    return ok;
  endfunction : access_ok

  // Byte of the held fuses or key at an offset
  function automatic logic [7:0] local_byte(input fcdl_fuse_type f,
                                            input fcdl_section_type sec,
                                            input logic [15:0] a);
    logic [7:0] b;
    logic [7:0] ofs;
    b = ZERO_BYTE;
    ofs = a[7:0];
    if (sec == sec_lock && ofs >= LOCK_OFS_KEY &&
        ofs < LOCK_OFS_KEY + LOCK_KEY_BYTES)
      b = f.key[8*(ofs - LOCK_OFS_KEY) +: 8];
    else if (sec == sec_fuse)
    begin
      if (ofs == FUSE_OFS_SYSTEM_CONFIG_ZERO_FUSE)
        b = f.system_config_zero_fuse;
      else if (ofs == FUSE_OFS_SYSTEM_CONFIG_ONE_FUSE)
        b = f.system_config_one_fuse;
      else if (ofs == FUSE_OFS_CODE_REGION_SIZE)
        b = f.code_size;
      else if (ofs == FUSE_OFS_BOOT_REGION_SIZE)
        b = f.boot_size;
    end
    return b;
  endfunction : local_byte

  assign key_ok = (held.key == UNLOCK_KEY);

  // Sequencing from reset: load, wait, run
  always_comb
  begin
    next_state = state;
    next_held = held;
    timer_start = 1'b0;
    unique case (state)
      st_load:
      begin
        next_held = fuse_in;
        next_state = st_delay;
      end
      st_delay:
      begin
        timer_start = 1'b1;
        if (timer_done)
          next_state = st_run;
      end
      st_run:
        next_state = st_run;
    endcase
    // Key mirror follows debugger key writes and full erase
    if (state != st_load)
    begin
      if (dbg_req.valid && !pend && dbg_req.write &&
          dbg_req.section == sec_lock &&
          access_ok(dbg_req.section, 1'b1, dbg_req.fuse_cmd,
                    1'b1, !key_ok) &&
          dbg_req.addr[7:0] >= LOCK_OFS_KEY &&
          dbg_req.addr[7:0] < LOCK_OFS_KEY + LOCK_KEY_BYTES)
        next_held.key[8*(dbg_req.addr[7:0] - LOCK_OFS_KEY) +: 8] =
          dbg_req.wdata;
      if (dbg_erase)
        next_held.key = UNLOCK_KEY;
    end
  end

  // Decoded settings come only from the held copy
  always_comb
  begin
    next_cfg.debug_pin_function_select =
      held.system_config_zero_fuse[DEBUG_PIN_BIT];
    next_cfg.debug_pin_pullup = held.system_config_zero_fuse[DEBUG_PIN_BIT];
    next_cfg.reset_pin_function_select =
      held.system_config_zero_fuse[RESET_PIN_BIT];
    next_cfg.eeprom_keep_on_erase = held.system_config_zero_fuse[EEPROM_KEEP_BIT];
    next_cfg.supply_dual =
      (held.system_config_one_fuse[SUPPLY_MSB:SUPPLY_LSB] == SUPPLY_DUAL);
    next_cfg.supply_single =
      (held.system_config_one_fuse[SUPPLY_MSB:SUPPLY_LSB] == SUPPLY_SINGLE);
    next_cfg.supply_reserved =
      !next_cfg.supply_dual && !next_cfg.supply_single;
    if (held.boot_size == BOOT_SIZE_ALL)
    begin
      next_cfg.boot_region_end = FLASH_END;
      next_cfg.code_region_end = FLASH_END;
    end
    else
    begin
      next_cfg.boot_region_end =
        (REGION_ADDR_W+1)'(held.boot_size) << REGION_SHIFT;
      next_cfg.code_region_end =
        (REGION_ADDR_W+1)'(held.code_size) << REGION_SHIFT;
    end
  end

  // Debugger path; one access in flight at a time
  always_comb
  begin
    next_pend = pend;
    next_dbg_mem = '0;
    next_dbg_resp = '0;
    next_erase_flash = 1'b0;
    next_erase_sram = 1'b0;
    next_erase_eeprom = 1'b0;
    if (state != st_load)
    begin
      if (dbg_erase)
      begin
        // User row has no erase strobe, so it survives
        next_erase_flash = 1'b1;
        next_erase_sram = 1'b1;
        next_erase_eeprom = !cfg.eeprom_keep_on_erase;
      end
      if (pend)
      begin
        if (dbg_mem_rvalid)
        begin
          next_pend = 1'b0;
          next_dbg_resp.done = 1'b1;
          next_dbg_resp.rdata = dbg_mem_rdata;
        end
      end
      else if (dbg_req.valid)
      begin
        if (access_ok(dbg_req.section, dbg_req.write, dbg_req.fuse_cmd,
                      1'b1, !key_ok))
        begin
          next_dbg_mem = dbg_req;
          if (dbg_req.write)
            next_dbg_resp.done = 1'b1;
          else
            next_pend = 1'b1;
        end
        else
        begin
          // Refused accesses still complete, carrying INVALID_DATA
          next_dbg_resp.done = 1'b1;
          next_dbg_resp.refused = 1'b1;
          next_dbg_resp.rdata = INVALID_DATA;
        end
      end
    end
  end

  // Processor path; lock state never narrows it
  always_comb
  begin
    next_cpu_mem = '0;
    next_cpu_resp = '0;
    if (cpu_req.valid && state != st_load)
    begin
      if (!access_ok(cpu_req.section, cpu_req.write, cpu_req.fuse_cmd,
                     1'b0, !key_ok))
      begin
        next_cpu_resp.done = 1'b1;
        next_cpu_resp.refused = 1'b1;
      end
      else if (!cpu_req.write &&
               (cpu_req.section == sec_fuse ||
                cpu_req.section == sec_lock))
      begin
        next_cpu_resp.done = 1'b1;
        next_cpu_resp.rdata =
          local_byte(held, cpu_req.section, cpu_req.addr);
      end
      else
        next_cpu_mem = cpu_req;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= st_load;
      held <= '0;
      cfg <= '0;
      pend <= 1'b0;
      dbg_mem <= '0;
      dbg_resp <= '0;
      cpu_mem <= '0;
      cpu_resp <= '0;
      erase_flash <= 1'b0;
      erase_sram <= 1'b0;
      erase_eeprom <= 1'b0;
      locked <= 1'b1;
    end
    else if (ce)
    begin
      state <= next_state;
      held <= next_held;
      cfg <= next_cfg;
      pend <= next_pend;
      dbg_mem <= next_dbg_mem;
      dbg_resp <= next_dbg_resp;
      cpu_mem <= next_cpu_mem;
      cpu_resp <= next_cpu_resp;
      erase_flash <= next_erase_flash;
      erase_sram <= next_erase_sram;
      erase_eeprom <= next_erase_eeprom;
      locked <= (next_held.key != UNLOCK_KEY);
    end
  end

  assign config_valid = (state != st_load);
  assign code_exec_en = (state == st_run);

  fcdl_startup_timer #(
    .CYCLES_MS(CYCLES_MS)
  ) u_timer (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .start(timer_start),
    .delay_code(held.system_config_one_fuse[STARTUP_MSB:STARTUP_LSB]),
    .done(timer_done)
  );

endmodule : fcdl_fuse_lock
`default_nettype wire

// ---- tb/fcdl_fuse_lock_asserts.sv ----
// Port assertions for the fuse decode and debugger lock block.
`timescale 1ns/1ps
`default_nettype none
module fcdl_fuse_lock_asserts
  import fcdl_pkg::*;
#(
  parameter int FLASH_BYTES = FLASH_BYTES_DEFAULT
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Inputs seen
  input wire fcdl_fuse_type fuse_in,
  input wire fcdl_req_type dbg_req,
  input wire logic dbg_erase,
  input wire fcdl_req_type cpu_req,
  // Outputs seen
  input wire fcdl_req_type dbg_mem,
  input wire fcdl_resp_type dbg_resp,
  input wire fcdl_req_type cpu_mem,
  input wire fcdl_resp_type cpu_resp,
  input wire logic erase_flash,
  input wire logic erase_sram,
  input wire logic erase_eeprom,
  input wire fcdl_cfg_type cfg,
  input wire logic locked,
  input wire logic config_valid,
  input wire logic code_exec_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic dv;
  logic cv;
  logic urw;
  fcdl_fuse_type snap;
  // Mirror of the capture; fuse changes after start must not show
  always_ff @(posedge core_clk)
  begin
    if (!config_valid)
      snap <= fuse_in;
  end
  // Erase in the same cycle wins, so keep it out of request checks
  assign dv = dbg_req.valid && config_valid && !dbg_erase;
  assign cv = cpu_req.valid && config_valid;
  assign urw = dbg_req.write && dbg_req.fuse_cmd &&
    dbg_req.section == sec_user_row_a;
  pin_fields_a: assert property ($past(config_valid) |->
    cfg.debug_pin_function_select == snap.system_config_zero_fuse[4] &&
    cfg.debug_pin_pullup == snap.system_config_zero_fuse[4] &&
    cfg.reset_pin_function_select == snap.system_config_zero_fuse[3] &&
    cfg.eeprom_keep_on_erase == snap.system_config_zero_fuse[0])
    else $error("pin or keep setting wrong");
  supply_code_a: assert property ($past(config_valid) |->
    cfg.supply_dual == (snap.system_config_one_fuse[4:3] == 2'h1) &&
    cfg.supply_single == (snap.system_config_one_fuse[4:3] == 2'h2) &&
    cfg.supply_reserved == (snap.system_config_one_fuse[4] == snap.system_config_one_fuse[3]))
    else $error("supply decode wrong");
  region_ends_a: assert property ($past(config_valid) |->
    cfg.boot_region_end == (snap.boot_size == 8'h00 ?
    18'(FLASH_BYTES) : {1'b0, snap.boot_size, 9'h000}) &&
    cfg.code_region_end == (snap.boot_size == 8'h00 ?
    18'(FLASH_BYTES) : {1'b0, snap.code_size, 9'h000}))
    else $error("region end wrong");
  key_decode_a: assert property ($rose(config_valid) |=>
    locked == (snap.key != UNLOCK_KEY))
    else $error("lock state after start wrong");
  startup_bound_a: assert property ($rose(config_valid) |->
    ##[1:400] code_exec_en)
    else $error("code execution never enabled");
  erase_pulse_a: assert property (dbg_erase && config_valid |=>
    erase_flash && erase_sram && !locked &&
    erase_eeprom == !cfg.eeprom_keep_on_erase)
    else $error("erase answer wrong");
  locked_refuse_a: assert property (dv && locked && !urw |=>
    dbg_resp.done && dbg_resp.refused && !dbg_mem.valid &&
    dbg_resp.rdata == INVALID_DATA)
    else $error("locked debugger access not refused");
  user_row_a: assert property (dv && locked && urw |=>
    dbg_mem.valid && dbg_resp.done && !dbg_resp.refused)
    else $error("locked user row write not taken");
  sign_row_a: assert property (dv && !locked && dbg_req.write &&
    dbg_req.section == sec_signature_row |=> dbg_resp.done && dbg_resp.refused)
    else $error("signature row write not refused");
  key_write_a: assert property (dv && !locked && dbg_req.write &&
    dbg_req.section == sec_lock && dbg_req.addr == 16'h0000 &&
    dbg_req.wdata != UNLOCK_KEY[7:0] |=> locked)
    else $error("bad key byte did not lock");
  cpu_refuse_a: assert property (cv && cpu_req.write &&
    cpu_req.section inside {sec_signature_row, sec_fuse, sec_lock} |=>
    cpu_resp.done && cpu_resp.refused && !cpu_mem.valid)
    else $error("processor write not refused");
  cpu_forward_a: assert property (cv && cpu_req.section == sec_flash |=>
    cpu_mem.valid && cpu_mem.addr == $past(cpu_req.addr))
    else $error("processor access not forwarded");
endmodule : fcdl_fuse_lock_asserts
bind fcdl_fuse_lock fcdl_fuse_lock_asserts #(.FLASH_BYTES(FLASH_BYTES))
  i_fcdl_fuse_lock_asserts (.core_clk(core_clk), .rstn(rstn),
  .fuse_in(fuse_in), .dbg_req(dbg_req), .dbg_erase(dbg_erase),
  .cpu_req(cpu_req), .dbg_mem(dbg_mem), .dbg_resp(dbg_resp),
  .cpu_mem(cpu_mem), .cpu_resp(cpu_resp), .erase_flash(erase_flash),
  .erase_sram(erase_sram), .erase_eeprom(erase_eeprom), .cfg(cfg),
  .locked(locked), .config_valid(config_valid),
  .code_exec_en(code_exec_en));
`default_nettype wire

// ---- tb/fcdl_mem_model.sv ----
// Far-side memory answering forwarded debugger reads.
`timescale 1ns/1ps
`default_nettype none
module fcdl_mem_model
  import fcdl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Forwarded request and answer
  input wire fcdl_req_type req,
  input wire logic slow,
  output logic rvalid,
  output logic [7:0] rdata
);
  logic [2:0] cnt;
  logic [7:0] held;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt <= 3'h0;
      held <= 8'h00;
      rvalid <= 1'b0;
      rdata <= 8'h00;
    end
    else
    begin
      rvalid <= cnt == 3'h1;
      // Data toggles outside the answer so stale values never match
      rdata <= cnt == 3'h1 ? held : ~rdata;
      if (req.valid && !req.write)
      begin
        cnt <= slow ? 3'h6 : 3'h1;
        held <= req.addr[7:0] ^ 8'h3C;
      end
      else if (cnt != 3'h0)
        cnt <= cnt - 3'h1;
    end
  end
endmodule : fcdl_mem_model
`default_nettype wire

// ---- tb/fcdl_fuse_lock_bench.sv ----
// Self-checking bench for fuse decoding and debugger lock.
`timescale 1ns/1ps
`default_nettype none
module fcdl_fuse_lock_bench
  import fcdl_pkg::*;
;
  localparam int CMS = 4;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic slow = 1'b0;
  logic dbg_erase = 1'b0;
  logic rvalid;
  logic [7:0] rdata;
  logic fwd;
  fcdl_fuse_type fuse_in = '0;
  fcdl_req_type dbg_req = '0;
  fcdl_req_type cpu_req = '0;
  fcdl_req_type dbg_mem;
  fcdl_req_type cpu_mem;
  fcdl_resp_type dbg_resp;
  fcdl_resp_type cpu_resp;
  fcdl_resp_type r;
  fcdl_cfg_type cfg;
  logic erase_flash;
  logic erase_sram;
  logic erase_eeprom;
  logic locked;
  logic config_valid;
  logic code_exec_en;
  int n_errors = 0;
  int compares = 0;
  logic [31:0] seed = 32'h0000_9e4e;
  always #12.5 core_clk = ~core_clk;
  fcdl_fuse_lock #(.CYCLES_MS(CMS)) i_fcdl_fuse_lock (
    .core_clk(core_clk), .rstn(rstn), .ce(ce), .fuse_in(fuse_in),
    .dbg_req(dbg_req), .dbg_erase(dbg_erase), .dbg_mem_rvalid(rvalid),
    .dbg_mem_rdata(rdata), .dbg_mem(dbg_mem), .dbg_resp(dbg_resp),
    .cpu_req(cpu_req), .cpu_mem(cpu_mem), .cpu_resp(cpu_resp),
    .erase_flash(erase_flash), .erase_sram(erase_sram),
    .erase_eeprom(erase_eeprom), .cfg(cfg), .locked(locked),
    .config_valid(config_valid), .code_exec_en(code_exec_en));
  fcdl_mem_model i_fcdl_mem_model (.core_clk(core_clk), .rstn(rstn),
    .req(dbg_mem), .slow(slow), .rvalid(rvalid), .rdata(rdata));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function automatic logic [2:0] supply(input logic [1:0] c);
    supply = c == 2'h1 ? 3'h4 : (c == 2'h2 ? 3'h2 : 3'h1);
  endfunction : supply
  function automatic int wait_for(input logic [2:0] c);
    wait_for = c == 3'h0 ? 0 : (1 << (c - 1)) * CMS;
  endfunction : wait_for
  task automatic check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask : check
  task automatic summarize;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic dbg(input logic wr, input logic fc,
    input fcdl_section_type s, input logic [15:0] a, input logic [7:0] d);
    int i;
    @(posedge core_clk);
    dbg_req <= '{1'b1, wr, fc, s, a, d};
    @(posedge core_clk);
    dbg_req.valid <= 1'b0;
    #1;
    fwd = dbg_mem.valid;
    for (i = 0; i < 20 && dbg_resp.done !== 1'b1; i++)
      @(posedge core_clk) #1;
    r = dbg_resp;
    check("done", 1, r.done);
  endtask : dbg
  task automatic cpu(input logic wr, input fcdl_section_type s,
    input logic [15:0] a);
    @(posedge core_clk);
    cpu_req <= '{1'b1, wr, 1'b0, s, a, 8'h5A};
    @(posedge core_clk);
    cpu_req.valid <= 1'b0;
    #1;
  endtask : cpu
  task automatic boot(input fcdl_fuse_type f);
    int n;
    int e;
    @(posedge core_clk);
    rstn <= 1'b0;
    fuse_in <= f;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    // Enable held low first: nothing may be captured yet
    ce <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    check("frozen", 0, config_valid);
    @(posedge core_clk);
    ce <= 1'b1;
    e = wait_for(f.system_config_one_fuse[2:0]);
    for (n = 0; n < 600 && code_exec_en !== 1'b1; n++)
      @(posedge core_clk) #1;
    check("delay", 1, n >= e && n <= e + 6);
    check("dbgpin", f.system_config_zero_fuse[4], cfg.debug_pin_function_select);
    check("pullup", f.system_config_zero_fuse[4], cfg.debug_pin_pullup);
    check("rstpin", f.system_config_zero_fuse[3], cfg.reset_pin_function_select);
    check("keep", f.system_config_zero_fuse[0], cfg.eeprom_keep_on_erase);
    check("supply", supply(f.system_config_one_fuse[4:3]), {cfg.supply_dual,
      cfg.supply_single, cfg.supply_reserved});
    e = f.boot_size == 8'h00 ? FLASH_BYTES_DEFAULT : f.boot_size * 512;
    check("boot", e, cfg.boot_region_end);
    e = f.boot_size == 8'h00 ? FLASH_BYTES_DEFAULT : f.code_size * 512;
    check("code", e, cfg.code_region_end);
    check("locked", f.key != UNLOCK_KEY, locked);
  endtask : boot
  task automatic traffic(input fcdl_fuse_type f);
    logic [15:0] a;
    seed = lfsr(seed);
    a = seed[15:0];
    slow = seed[16];
    dbg(0, 0, sec_flash, a, 8'h00);
    check("read", {2'b10, a[7:0] ^ 8'h3C}, {fwd, r.refused, r.rdata});
    dbg(1, 0, sec_signature_row, a, 8'h11);
    check("signwr", 2'b01, {fwd, r.refused});
    cpu(0, sec_fuse, 16'h0007);
    check("cpurd", {1'b1, f.code_size},
      {cpu_resp.done, cpu_resp.rdata});
    cpu(1, sec_fuse, 16'h0005);
    check("cpuwr", 3'h6,
      {cpu_resp.done, cpu_resp.refused, cpu_mem.valid});
    // Low bit set keeps the byte off the valid key byte
    dbg(1, 0, sec_lock, 16'h0000, {a[7:1], 1'b1});
    check("keywr", 1, locked);
    dbg(0, 0, sec_eeprom, a, 8'h00);
    check("lkrd", 10'h100, {fwd, r.refused, r.rdata});
    dbg(1, 1, sec_user_row_a, a, 8'h77);
    check("urwr", 2'b10, {fwd, r.refused});
    dbg(0, 1, sec_user_row_a, a, 8'h00);
    check("urrd", 2'b01, {fwd, r.refused});
    cpu(1, sec_flash, a);
    check("cpufw", {1'b1, a}, {cpu_mem.valid, cpu_mem.addr});
    @(posedge core_clk);
    dbg_erase <= 1'b1;
    fuse_in <= ~f;
    @(posedge core_clk);
    dbg_erase <= 1'b0;
    #1;
    check("erase", {3'h6, !f.system_config_zero_fuse[0]}, {erase_flash, erase_sram,
      locked, erase_eeprom});
    dbg(0, 0, sec_sram, a, 8'h00);
    check("reread", 2'b10, {fwd, r.refused});
    cpu(0, sec_fuse, 16'h0008);
    check("hold", {1'b1, f.boot_size, f.system_config_zero_fuse[4]}, {cpu_resp.done,
      cpu_resp.rdata, cfg.debug_pin_function_select});
  endtask : traffic
  initial
  begin
    fcdl_fuse_type f;
    int k;
    for (k = 0; k < 8; k++)
    begin
      seed = lfsr(seed);
      f[63:32] = seed;
      seed = lfsr(seed);
      f[31:0] = seed;
      f.system_config_one_fuse[2:0] = k[2:0];
      f.system_config_one_fuse[4:3] = k[1:0];
      // Boundary sizes: whole flash as boot, then the largest count
      f.boot_size = k == 0 ? 8'h00 : (k == 2 ? 8'hFF : f.boot_size);
      f.key = k[0] ? seed ^ UNLOCK_KEY : UNLOCK_KEY;
      boot(f);
      if (!k[0])
        traffic(f);
      else
      begin
        dbg(0, 0, sec_flash, seed[15:0], 8'h00);
        check("fuselk", f.key != UNLOCK_KEY, r.refused);
      end
    end
    summarize();
  end
  initial
  begin
    #(25 * 20000);
    n_errors++;
    summarize();
  end
endmodule : fcdl_fuse_lock_bench
`default_nettype wire
